// ### hw/lpm_defs.svh
// Timing counts, opcodes and register fields for the low-power mode controller
`ifndef LPM_DEFS_SVH
`define LPM_DEFS_SVH
`define LPM_STOP_OPCODE 8'h8e
`define LPM_WAIT_OPCODE 8'h8f
`define LPM_OSC_START_CYCLES 4096
`define LPM_MASK_ENABLE_ALL 2'h2
`define LPM_MASK_RESET_LEVEL 2'h3
`define LPM_ADDR_CTRL 4'h0
`define LPM_ADDR_STATUS 4'h4
`define LPM_ADDR_OPT 4'h8
`define LPM_ADDR_MASK 4'hc
`define LPM_CTRL_TBIE_BIT 0
`define LPM_OPT_WDSTOP_BIT 0
`endif

// ### hw/lpm_pkg.sv
// Types for the low-power mode controller
package lpm_pkg;
  typedef enum logic [2:0] {
    ST_RUN,
    ST_WAIT,
    ST_CSTOP,
    ST_FSTOP,
    ST_OSC_START
  } mode_e;
endpackage

// ### hw/low_power_mode_control.sv
// Power-mode controller with wait, clocked-stop and full-stop modes
// Function
// - The wait-for-interrupt instruction stops the core while peripherals keep their clock.
// - Entering wait mode forces the two interrupt mask bits to 10b.
// - Wait mode keeps all state and is left only on an interrupt or a reset.
// - The stop instruction enters clocked-stop if the time-base enable is 1, else full-stop.
// - In clocked-stop only the oscillator and time-base counter are clocked.
// - Clocked-stop ends on a time-base, designated interrupt or reset; interrupts resume at once.
// - A reset exit from clocked-stop inserts the oscillator start delay; an interrupt exit does not.
// - Entering either stop mode forces the mask to 10b; a pending designated interrupt wakes clocked-stop at once.
// - With the time-base enable set, clocked-stop entry does not raise a watchdog reset.
// - In full-stop the oscillator is off and core and peripherals halt.
// - Full-stop ends on designated interrupts or reset after a 4096-cycle oscillator start.
// - With the watchdog stop option and the time-base enable clear, stop while watchdog is on gives a watchdog reset.
// - Servicing a wake interrupt pushes the condition codes and sets the mask to its priority.
// - Opcode 0x8e is decoded as the stop instruction.
`include "lpm_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module low_power_mode_control #(
  parameter int OSC_START_CYCLES = `LPM_OSC_START_CYCLES
) (
  input wire logic REF_CLK_I,
  input wire logic NRST_I,
  input wire logic [3:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  output logic WB_ACK_O,
  input wire logic OPCODE_VALID_I,
  input wire logic [7:0] OPCODE_I,
  input wire logic IRQ_PENDING_I,
  input wire logic TB_IRQ_I,
  input wire logic STOP_WAKE_IRQ_I,
  input wire logic [1:0] IRQ_PRIO_I,
  input wire logic IRQ_TAKEN_I,
  input wire logic COND_POP_I,
  input wire logic WDG_ENABLED_I,
  input wire logic WAKE_RESET_I,
  output logic CPU_CLK_EN_O,
  output logic PERIPH_CLK_EN_O,
  output logic OSC_EN_O,
  output logic TB_CLK_EN_O,
  output logic WDG_RESET_O,
  output logic RESET_VECTOR_O,
  output logic [1:0] IRQ_MASK_O
);
  lpm_pkg::mode_e mode_r, mode_nxt;
  logic [12:0] cnt_r, cnt_nxt;
  logic [1:0] mask_r, mask_nxt;
  logic [1:0] saved_r, saved_nxt;
  logic rst_exit_r, rst_exit_nxt;
  logic wdg_r, wdg_nxt;
  logic rstv_r, rstv_nxt;
  logic tbie_r, tbie_nxt;
  logic wdstop_r, wdstop_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic is_stop, is_wait, wb_req;
  logic [12:0] osc_last;

  assign osc_last = 13'(OSC_START_CYCLES - 1);
  assign is_stop = OPCODE_VALID_I && (OPCODE_I == `LPM_STOP_OPCODE);
  assign is_wait = OPCODE_VALID_I && (OPCODE_I == `LPM_WAIT_OPCODE);
  assign wb_req = WB_CYC_I && WB_STB_I && !ack_r;

  always_comb
  begin
    mode_nxt = mode_r;
    cnt_nxt = cnt_r;
    mask_nxt = mask_r;
    saved_nxt = saved_r;
    rst_exit_nxt = rst_exit_r;
    wdg_nxt = 1'b0;
    rstv_nxt = 1'b0;
    unique case (mode_r)
      lpm_pkg::ST_RUN:
      begin
        if (is_wait)
        begin
          mode_nxt = lpm_pkg::ST_WAIT;
          mask_nxt = `LPM_MASK_ENABLE_ALL;
        end
        else if (is_stop)
        begin
          if (tbie_r)
          begin
            mode_nxt = lpm_pkg::ST_CSTOP;
            mask_nxt = `LPM_MASK_ENABLE_ALL;
          end
          else if (WDG_ENABLED_I && wdstop_r)
            wdg_nxt = 1'b1;
          else
          begin
            mode_nxt = lpm_pkg::ST_FSTOP;
            mask_nxt = `LPM_MASK_ENABLE_ALL;
          end
        end
      end
      lpm_pkg::ST_WAIT:
      begin
        // Any interrupt or reset releases the core next cycle
        if (WAKE_RESET_I)
        begin
          mode_nxt = lpm_pkg::ST_RUN;
          rstv_nxt = 1'b1;
        end
        else if (IRQ_PENDING_I)
          mode_nxt = lpm_pkg::ST_RUN;
      end
      lpm_pkg::ST_CSTOP:
      begin
        if (WAKE_RESET_I)
        begin
          mode_nxt = lpm_pkg::ST_OSC_START;
          cnt_nxt = '0;
          rst_exit_nxt = 1'b1;
        end
        else if (TB_IRQ_I || STOP_WAKE_IRQ_I)
          mode_nxt = lpm_pkg::ST_RUN;
      end
      lpm_pkg::ST_FSTOP:
      begin
        if (WAKE_RESET_I || STOP_WAKE_IRQ_I)
        begin
          mode_nxt = lpm_pkg::ST_OSC_START;
          cnt_nxt = '0;
          rst_exit_nxt = WAKE_RESET_I;
        end
      end
      lpm_pkg::ST_OSC_START:
      begin
        if (cnt_r == osc_last)
        begin
          mode_nxt = lpm_pkg::ST_RUN;
          rstv_nxt = rst_exit_r;
          rst_exit_nxt = 1'b0;
        end
        else
          cnt_nxt = cnt_r + 13'h1;
      end
      // Unused state codes fall back to run rather than lock the core out
      default: mode_nxt = lpm_pkg::ST_RUN;
    endcase
    // Reset vector takes the top level, mask restore follows pop
    if (rstv_nxt)
      mask_nxt = `LPM_MASK_RESET_LEVEL;
    else if (IRQ_TAKEN_I && mode_r == lpm_pkg::ST_RUN)
    begin
      saved_nxt = mask_r;
      mask_nxt = IRQ_PRIO_I;
    end
    else if (COND_POP_I && mode_r == lpm_pkg::ST_RUN)
      mask_nxt = saved_r;
  end

  always_comb
  begin
    tbie_nxt = tbie_r;
    wdstop_nxt = wdstop_r;
    ack_nxt = wb_req;
    dat_nxt = dat_r;
    if (wb_req)
    begin
      dat_nxt = 32'h0;
      unique case (WB_ADR_I)
        `LPM_ADDR_CTRL:
        begin
          if (WB_WE_I && WB_SEL_I[0])
            tbie_nxt = WB_DAT_I[`LPM_CTRL_TBIE_BIT];
          dat_nxt[`LPM_CTRL_TBIE_BIT] = tbie_r;
        end
        `LPM_ADDR_OPT:
        begin
          if (WB_WE_I && WB_SEL_I[0])
            wdstop_nxt = WB_DAT_I[`LPM_OPT_WDSTOP_BIT];
          dat_nxt[`LPM_OPT_WDSTOP_BIT] = wdstop_r;
        end
        `LPM_ADDR_STATUS: dat_nxt[2:0] = mode_r;
        `LPM_ADDR_MASK: dat_nxt[1:0] = mask_r;
        default: dat_nxt = 32'h0;
      endcase
    end
  end

  // Mode, start counter and mask state
  always_ff @(posedge REF_CLK_I)
  begin
    if (!NRST_I)
    begin
      mode_r <= lpm_pkg::ST_RUN;
      cnt_r <= '0;
      mask_r <= `LPM_MASK_RESET_LEVEL;
      saved_r <= `LPM_MASK_RESET_LEVEL;
      rst_exit_r <= 1'b0;
      wdg_r <= 1'b0;
      rstv_r <= 1'b0;
    end
    else
    begin
      mode_r <= mode_nxt;
      cnt_r <= cnt_nxt;
      mask_r <= mask_nxt;
      saved_r <= saved_nxt;
      rst_exit_r <= rst_exit_nxt;
      wdg_r <= wdg_nxt;
      rstv_r <= rstv_nxt;
    end
  end

  // Register bus state
  always_ff @(posedge REF_CLK_I)
  begin
    if (!NRST_I)
    begin
      tbie_r <= 1'b0;
      wdstop_r <= 1'b0;
      ack_r <= 1'b0;
      dat_r <= 32'h0;
    end
    else
    begin
      tbie_r <= tbie_nxt;
      wdstop_r <= wdstop_nxt;
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  // Clock gates are decoded from state so they change with the mode edge
  assign CPU_CLK_EN_O = (mode_r == lpm_pkg::ST_RUN);
  assign PERIPH_CLK_EN_O = (mode_r == lpm_pkg::ST_RUN) || (mode_r == lpm_pkg::ST_WAIT);
  assign OSC_EN_O = (mode_r != lpm_pkg::ST_FSTOP);
  assign TB_CLK_EN_O = OSC_EN_O && (mode_r != lpm_pkg::ST_OSC_START);
  assign WDG_RESET_O = wdg_r;
  assign RESET_VECTOR_O = rstv_r;
  assign IRQ_MASK_O = mask_r;
  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = dat_r;
endmodule
`default_nettype wire

// ### test/lpm_monitor.sv
// Port assertions for the power-mode controller
`timescale 1ns/1ps
`default_nettype none
module lpm_monitor (
  input wire logic REF_CLK_I,
  input wire logic NRST_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire logic OPCODE_VALID_I,
  input wire logic [7:0] OPCODE_I,
  input wire logic IRQ_PENDING_I,
  input wire logic TB_IRQ_I,
  input wire logic WDG_ENABLED_I,
  input wire logic WAKE_RESET_I,
  input wire logic CPU_CLK_EN_O,
  input wire logic PERIPH_CLK_EN_O,
  input wire logic OSC_EN_O,
  input wire logic TB_CLK_EN_O,
  input wire logic [1:0] IRQ_MASK_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!NRST_I);
  wire logic go = OPCODE_VALID_I && CPU_CLK_EN_O;
  wire logic in_wait = !CPU_CLK_EN_O && PERIPH_CLK_EN_O;
  wire logic in_cstop = OSC_EN_O && TB_CLK_EN_O && !PERIPH_CLK_EN_O;
  property p_ack; WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_wt; go && OPCODE_I == 8'h8f |=> in_wait; endproperty
  a_wt: assert property (p_wt) else $error("wait entry");
  property p_wm; go && OPCODE_I == 8'h8f |=> IRQ_MASK_O == 2'h2; endproperty
  a_wm: assert property (p_wm) else $error("wait mask");
  property p_hold; in_wait && !IRQ_PENDING_I && !WAKE_RESET_I |=> in_wait; endproperty
  a_hold: assert property (p_hold) else $error("left wait");
  property p_sm; go && OPCODE_I == 8'h8e && !WDG_ENABLED_I
    |=> IRQ_MASK_O == 2'h2 && !PERIPH_CLK_EN_O; endproperty
  a_sm: assert property (p_sm) else $error("stop mask");
  property p_tb; in_cstop && TB_IRQ_I && !WAKE_RESET_I |=> CPU_CLK_EN_O; endproperty
  a_tb: assert property (p_tb) else $error("slow wake");
  property p_off; !OSC_EN_O |-> !CPU_CLK_EN_O && !PERIPH_CLK_EN_O && !TB_CLK_EN_O; endproperty
  a_off: assert property (p_off) else $error("clock on");
  // Eight is the smallest start count in use, so this holds for any build
  property p_st; $rose(OSC_EN_O) |-> !CPU_CLK_EN_O [*8]; endproperty
  a_st: assert property (p_st) else $error("start short");
endmodule
bind low_power_mode_control lpm_monitor lpm_monitor_inst (.*);
`default_nettype wire

// ### test/core_model.sv
// Core model: takes a waking interrupt, returns once its flag clears
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic req_i,
  output var logic taken_o,
  output var logic pop_o
);
  logic busy_r = 1'b0;
  always @(posedge clk_i)
  begin
    taken_o <= run_i && req_i && !busy_r && !taken_o;
    pop_o <= busy_r && !req_i && !pop_o;
    if (taken_o)
      busy_r <= 1'b1;
    else if (pop_o)
      busy_r <= 1'b0;
  end
endmodule
`default_nettype wire

// ### test/tb_top.sv
// Bench for the power-mode controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic REF_CLK_I = 0, NRST_I = 0, WB_WE_I = 0, WB_CYC_I = 0, OPCODE_VALID_I = 0;
  logic IRQ_PENDING_I = 0, TB_IRQ_I = 0, STOP_WAKE_IRQ_I = 0, WDG_ENABLED_I = 0;
  logic WAKE_RESET_I = 0, IRQ_TAKEN_I, COND_POP_I, WB_ACK_O, CPU_CLK_EN_O, OSC_EN_O;
  logic PERIPH_CLK_EN_O, TB_CLK_EN_O, WDG_RESET_O, RESET_VECTOR_O;
  logic [3:0] WB_ADR_I = 0, WB_SEL_I = 4'hf;
  logic [31:0] WB_DAT_I = 0, WB_DAT_O;
  logic [7:0] OPCODE_I = 0;
  logic [1:0] IRQ_PRIO_I = 2'h1, IRQ_MASK_O;
  int err_total = 0, cmp_count = 0, ticks = 0, n;
  wire logic WB_STB_I = WB_CYC_I;
  always #20 REF_CLK_I = ~REF_CLK_I;
  // Short start count keeps the run brief; the wake counts below follow it
  localparam int START_CYCLES = 8;
  low_power_mode_control #(.OSC_START_CYCLES(START_CYCLES)) low_power_mode_control_inst (.*);
  core_model core_model_inst (.clk_i(REF_CLK_I), .run_i(CPU_CLK_EN_O),
    .req_i(IRQ_PENDING_I), .taken_o(IRQ_TAKEN_I), .pop_o(COND_POP_I));
  task report_and_stop;
    $display("errors %0d checks %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, e);
    cmp_count++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task tick(input int k);
    repeat (k) @(posedge REF_CLK_I);
  endtask
  // Outputs are looked at mid-cycle, where they are settled
  task look;
    @(negedge REF_CLK_I);
  endtask
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d, e);
    @(posedge REF_CLK_I);
    WB_CYC_I <= 1'b1;
    WB_WE_I <= w;
    WB_ADR_I <= a;
    WB_DAT_I <= d;
    do @(posedge REF_CLK_I); while (WB_ACK_O !== 1'b1);
    if (!w)
      chk(WB_DAT_O, e);
    WB_CYC_I <= 1'b0;
  endtask
  task exec(input logic [7:0] op);
    @(posedge REF_CLK_I);
    OPCODE_VALID_I <= 1'b1;
    OPCODE_I <= op;
    @(posedge REF_CLK_I);
    OPCODE_VALID_I <= 1'b0;
  endtask
  // Called at the edge that drives the wake; counts half-way points to the core restart
  task wake(input logic rv);
    n = 0;
    do
    begin
      look;
      n++;
    end
    while (CPU_CLK_EN_O !== 1'b1);
    chk(RESET_VECTOR_O, rv);
  endtask
  always @(posedge REF_CLK_I)
  begin
    ticks++;
    if (ticks == 3000)
    begin
      err_total++;
      report_and_stop;
    end
  end
  initial
  begin
    tick(12);
    NRST_I <= 1'b1;
    wb(0, 4'hc, 0, 32'h3);
    wb(0, 4'h2, 0, 0);
    exec(8'h8f);
    look;
    chk({CPU_CLK_EN_O, PERIPH_CLK_EN_O, IRQ_MASK_O}, 4'h6);
    @(posedge REF_CLK_I);
    IRQ_PENDING_I <= 1'b1;
    wake(0);
    chk(n, 2);
    tick(4);
    look;
    chk(IRQ_MASK_O, 2'h1);
    @(posedge REF_CLK_I);
    IRQ_PENDING_I <= 1'b0;
    tick(4);
    look;
    chk(IRQ_MASK_O, 2'h2);
    wb(1, 4'h0, 1, 0);
    exec(8'h8e);
    wb(0, 4'h4, 0, 32'h2);
    look;
    chk({OSC_EN_O, TB_CLK_EN_O, PERIPH_CLK_EN_O}, 3'h6);
    @(posedge REF_CLK_I);
    TB_IRQ_I <= 1'b1;
    wake(0);
    chk(n, 2);
    @(posedge REF_CLK_I);
    TB_IRQ_I <= 1'b0;
    exec(8'h8e);
    WAKE_RESET_I <= 1'b1;
    wake(1);
    chk(n, 2 + START_CYCLES);
    @(posedge REF_CLK_I);
    WAKE_RESET_I <= 1'b0;
    wb(1, 4'h0, 0, 0);
    exec(8'h8e);
    look;
    chk({OSC_EN_O, CPU_CLK_EN_O, PERIPH_CLK_EN_O, TB_CLK_EN_O}, 0);
    @(posedge REF_CLK_I);
    STOP_WAKE_IRQ_I <= 1'b1;
    wake(0);
    chk(n, 2 + START_CYCLES);
    wb(1, 4'h0, 1, 0);
    exec(8'h8e);
    wake(0);
    chk(n, 2);
    @(posedge REF_CLK_I);
    STOP_WAKE_IRQ_I <= 1'b0;
    wb(1, 4'h0, 0, 0);
    wb(1, 4'h8, 1, 0);
    WDG_ENABLED_I <= 1'b1;
    exec(8'h8e);
    look;
    chk({WDG_RESET_O, CPU_CLK_EN_O}, 2'h3);
    wb(1, 4'h0, 1, 0);
    exec(8'h8e);
    look;
    chk({WDG_RESET_O, OSC_EN_O, PERIPH_CLK_EN_O}, 3'h2);
    @(posedge REF_CLK_I);
    NRST_I <= 1'b0;
    tick(2);
    NRST_I <= 1'b1;
    look;
    chk({CPU_CLK_EN_O, IRQ_MASK_O}, 3'h7);
    wb(0, 4'h0, 0, 32'h0);
    report_and_stop;
  end
endmodule
`default_nettype wire
